// ---- verilog/tdm_slot_access_unit.sv ----
// Operation
// - Four byte registers, each with a selection choosing time slot 0 to 11.
// - Line-select bit sends the register's output byte onto DU or DD.
// - Output slot and line always come from the register's own selection.
// - Without cross-input, input uses own slot on the line opposite the output.
// - With cross-input, each pair member takes input slot/line from its partner.
// - Input and output enables per register; disabled input keeps stored byte.
// - Bus-monitor enable makes first register of a pair capture slot 11.
// - Transfer interrupt two bit clocks after slot on DU output, one on DD.
// - One bit clock equals two data clock periods.
// - Acknowledge due one or zero bit clocks before overflow slot, else overflow.
// - Both unmasked: overflow relates only to the same register's transfer.
// - Transfer masked, overflow unmasked: overflow relates to every enabled transfer.
// - Mask bits suppress the matching transfer and overflow interrupts.
// - Reading status clears all transfer and overflow flags.
// - Status holds four transfer flags and four overflow flags.
// - Data clock runs at twice the bit rate, bit clock at bit rate.
// - Bits launched on first data-clock rise, sampled on second's falling edge.
// - Any pending unmasked source pulls the active-low interrupt output.
`timescale 1ns/1ps
`default_nettype none
`include "tdm_slot_access_cfg.svh"

module tdm_slot_access_unit
    import tdm_slot_access_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset,
    // Frame timing
    input  wire logic                    dcl,
    input  wire logic                    fsc,
    // Data lines, three signals each
    input  wire logic                    duIn,
    output logic                         duOut,
    output logic                         duOe_n,
    input  wire logic                    ddIn,
    output logic                         ddOut,
    output logic                         ddOe_n,
    // Configuration
    input  wire slot_port_select_t [3:0] slotPortSelect,
    input  wire pair_control_t [1:0]     pairControl,
    input  wire logic [7:0]              transferIrqMask,
    // Host data access
    input  wire logic [3:0]              writeStrobe,
    input  wire logic [7:0]              writeData,
    output logic [3:0][7:0]              readData,
    input  wire logic [3:0]              transferAck,
    input  wire logic                    statusRead,
    output logic [7:0]                   status,
    output logic                         irq_n
);

    state_t st_r;
    state_t st_nxt;

    always_comb begin
        logic              dclRise;
        logic              dclFall;
        logic [3:0]        slotNow;
        logic [2:0]        bitInSlot;
        logic [6:0]        bitNow;
        slot_port_select_t inSel;
        logic [3:0]        inSlot;
        logic              inLine;
        logic              inBit;
        logic              inEnable;
        logic              outEnable;
        logic [6:0]        stiPos;
        logic [6:0]        ackPos;
        logic [3:0]        stiEvent;
        logic [3:0]        stovCheck;
        logic [3:0]        related;
        logic              duDrive;
        logic              ddDrive;
        logic              duBit;
        logic              ddBit;

        st_nxt    = st_r;
        dclRise   = dcl & ~st_r.dclPrev;
        dclFall   = ~dcl & st_r.dclPrev;
        slotNow   = '0;
        bitInSlot = '0;
        bitNow    = '0;
        stiEvent  = '0;
        stovCheck = '0;
        related   = '0;
        duDrive   = 1'b0;
        ddDrive   = 1'b0;
        duBit     = 1'b0;
        ddBit     = 1'b0;
        inSel     = '0;
        inSlot    = '0;
        inLine    = 1'b0;
        inBit     = 1'b0;
        inEnable  = 1'b0;
        outEnable = 1'b0;
        stiPos    = '0;
        ackPos    = '0;

        st_nxt.dclPrev = dcl;

        // Frame position in data clocks, two per bit
        if (dclRise) begin
            st_nxt.fscPrev = fsc;
            if (fsc && !st_r.fscPrev) begin
                st_nxt.dclCnt = `RESET_DCL_CNT;
            end else if (st_r.dclCnt == `LAST_DCL) begin
                st_nxt.dclCnt = `RESET_DCL_CNT;
            end else begin
                st_nxt.dclCnt = st_r.dclCnt + 8'h01;
            end
        end

        // Position of the edge being handled; a rise takes its new count
        slotNow   = st_nxt.dclCnt[7:4];
        bitInSlot = st_nxt.dclCnt[3:1];
        bitNow    = st_nxt.dclCnt[7:1];

        // Status read clears first so a same-cycle event survives
        if (statusRead) begin
            st_nxt.transfer_irq  = '0;
            st_nxt.transfer_overflow_irq = '0;
        end
        st_nxt.pend = st_r.pend & ~transferAck;

        for (int i = 0; i < 4; i++) begin
            // Input selection
            inSel    = pairControl[i / 2].swap ? slotPortSelect[i ^ 1] : slotPortSelect[i];
            inSlot   = inSel.slot;
            inLine   = ~inSel.lineSel;
            inEnable = pairControl[i / 2].inEn[i % 2];
            if ((i % 2 == 0) && pairControl[i / 2].busMonitorEnable) begin
                inSlot = `TIC_SLOT;
                inLine = slotPortSelect[i].lineSel;
            end
            inBit = inLine ? ddIn : duIn;

            // Sample on falling edge of second data clock of the bit
            if (dclFall && st_r.dclCnt[0] && inEnable && slotNow == inSlot) begin
                st_nxt.shift[i] = {st_r.shift[i][6:0], inBit};
                if (bitInSlot == `LAST_BIT_IN_SLOT) begin
                    st_nxt.data[i] = {st_r.shift[i][6:0], inBit};
                end
            end
            if (writeStrobe[i]) begin
                st_nxt.data[i] = writeData;
            end

            // Output bit for the own slot and line
            outEnable = pairControl[i / 2].outEn[i % 2];
            if (outEnable && slotNow == slotPortSelect[i].slot) begin
                if (slotPortSelect[i].lineSel) begin
                    ddDrive = 1'b1;
                    ddBit   = ddBit | st_r.data[i][`LAST_BIT_IN_SLOT - bitInSlot];
                end else begin
                    duDrive = 1'b1;
                    duBit   = duBit | st_r.data[i][`LAST_BIT_IN_SLOT - bitInSlot];
                end
            end

            // Interrupt positions, in bits within the frame
            stiPos = 7'((({3'h0, slotPortSelect[i].slot} + 7'h01) * {3'h0, `BITS_PER_SLOT}
                     + (slotPortSelect[i].lineSel ? `STI_DELAY_DD : `STI_DELAY_DU)) % `FRAME_BITS);
            // Eight-bit sum: slot offset plus a whole frame overflows seven bits
            ackPos = 7'(({4'h0, slotPortSelect[i].slot} * {4'h0, `BITS_PER_SLOT} + {1'b0, `FRAME_BITS}
                     - {1'b0, (slotPortSelect[i].lineSel ? `ACK_LEAD_DD : `ACK_LEAD_DU)})
                     % {1'b0, `FRAME_BITS});
            if (dclRise && !st_nxt.dclCnt[0]) begin
                stiEvent[i]  = (bitNow == stiPos);
                stovCheck[i] = (bitNow == ackPos);
            end
        end

        // Overflow checks use pending transfers still unacknowledged
        for (int j = 0; j < 4; j++) begin
            if (stovCheck[j] && !transferIrqMask[4 + j]) begin
                related = transferIrqMask[j] ? st_nxt.pend : (st_nxt.pend & (4'h1 << j));
                if (|related) begin
                    st_nxt.transfer_overflow_irq[j] = 1'b1;
                    st_nxt.pend    = st_nxt.pend & ~related;
                end
            end
        end

        // Transfer events; set wins over acknowledge and status clear
        for (int k = 0; k < 4; k++) begin
            if (stiEvent[k] && !transferIrqMask[k]) begin
                st_nxt.transfer_irq[k]  = 1'b1;
                st_nxt.pend[k] = 1'b1;
            end
        end

        // Launch on rising edge of first data clock of each bit
        if (dclRise && !st_nxt.dclCnt[0]) begin
            st_nxt.duOut  = duBit;
            st_nxt.duOe_n = ~duDrive;
            st_nxt.ddOut  = ddBit;
            st_nxt.ddOe_n = ~ddDrive;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r        <= '0;
            st_r.duOe_n <= 1'b1;
            st_r.ddOe_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign duOut    = st_r.duOut;
    assign duOe_n   = st_r.duOe_n;
    assign ddOut    = st_r.ddOut;
    assign ddOe_n   = st_r.ddOe_n;
    assign readData = st_r.data;
    assign status   = {st_r.transfer_overflow_irq, st_r.transfer_irq};
    assign irq_n    = ~(|st_r.transfer_irq | |st_r.transfer_overflow_irq);

endmodule
`default_nettype wire

// ---- common/tdm_slot_access_cfg.svh ----
`ifndef TDM_SLOT_ACCESS_CFG_SVH
`define TDM_SLOT_ACCESS_CFG_SVH

// Frame geometry
`define SLOT_COUNT      4'hC
`define BITS_PER_SLOT   4'h8
`define FRAME_BITS      7'h60
`define LAST_DCL        8'hBF
`define LAST_BIT_IN_SLOT 3'h7
`define TIC_SLOT        4'hB

// Bit-clock delays from end of slot to transfer interrupt
`define STI_DELAY_DU    7'h2
`define STI_DELAY_DD    7'h1
// Bit-clock lead before overflow slot by which acknowledge is due
`define ACK_LEAD_DU     7'h1
`define ACK_LEAD_DD     7'h0

// Reset values
`define RESET_DCL_CNT   8'h00
`define RESET_BYTE      8'h00

`endif

// ---- common/tdm_slot_access_pkg.sv ----
package tdm_slot_access_pkg;

    // Per-register selection: lineSel 0 drives DU, 1 drives DD
    typedef struct packed {
        logic       lineSel;
        logic [3:0] slot;
    } slot_port_select_t;

    // Per-pair control
    typedef struct packed {
        logic       busMonitorEnable;
        logic       swap;
        logic [1:0] inEn;
        logic [1:0] outEn;
    } pair_control_t;

    typedef struct packed {
        logic            dclPrev;
        logic            fscPrev;
        logic [7:0]      dclCnt;
        logic [3:0][7:0] data;
        logic [3:0][7:0] shift;
        logic [3:0]      transfer_irq;
        logic [3:0]      transfer_overflow_irq;
        logic [3:0]      pend;
        logic            duOut;
        logic            duOe_n;
        logic            ddOut;
        logic            ddOe_n;
    } state_t;

endpackage

// ---- test/tdm_slot_access_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module tdm_slot_access_checker import tdm_slot_access_pkg::*; (
    // Clock and reset
    input wire logic                    clk,
    input wire logic                    reset,
    // Observed ports
    input wire logic                    dcl,
    input wire logic                    duOut,
    input wire logic                    duOe_n,
    input wire logic                    ddOe_n,
    input wire slot_port_select_t [3:0] slotPortSelect,
    input wire pair_control_t [1:0]     pairControl,
    input wire logic [7:0]              transferIrqMask,
    input wire logic                    statusRead,
    input wire logic [7:0]              status,
    input wire logic                    irq_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic       duUse;
    logic [3:0] quietCnt_r;
    // Any register set to drive DU
    assign duUse = (!slotPortSelect[0].lineSel && pairControl[0].outEn[0])
        || (!slotPortSelect[1].lineSel && pairControl[0].outEn[1])
        || (!slotPortSelect[2].lineSel && pairControl[1].outEn[0])
        || (!slotPortSelect[3].lineSel && pairControl[1].outEn[1]);
    always_ff @(posedge clk) begin
        if (reset || duUse) quietCnt_r <= 4'h0;
        else if (quietCnt_r != 4'hF) quietCnt_r <= quietCnt_r + 4'h1;
    end
    a_irq_follows_flags: assert property (irq_n == !(|status))
        else $error("irq_n disagrees with status");
    a_read_clears_flags: assert property (statusRead |=> (status & $past(status)) == 8'h00)
        else $error("flags survived a status read");
    a_flags_stay_set: assert property (|($past(status) & ~status) |-> $past(statusRead))
        else $error("flag fell without a read");
    a_mask_blocks_flag: assert property ((status & ~$past(status) & $past(transferIrqMask)) == 8'h00)
        else $error("masked flag was set");
    a_flag_at_bit_edge: assert property ((status & ~$past(status)) != 8'h00
        |-> $past(dcl) && !$past(dcl, 2))
        else $error("flag set away from a data clock rise");
    a_line_at_bit_edge: assert property ($changed({duOut, duOe_n}) |-> $past(dcl) && !$past(dcl, 2))
        else $error("DU changed away from a data clock rise");
    a_du_released_idle: assert property (quietCnt_r == 4'hF |-> duOe_n)
        else $error("DU driven with no register assigned");
    a_reset_quiet: assert property ($fell(reset) |-> irq_n && status == 8'h00 && duOe_n && ddOe_n)
        else $error("outputs not quiet after reset");
    cover property ($rose(status[0]));
    cover property ($rose(status[4]));
    cover property (!ddOe_n);
endmodule
bind tdm_slot_access_unit tdm_slot_access_checker tdm_slot_access_checker_inst (.clk, .reset, .dcl, .duOut,
    .duOe_n, .ddOe_n, .slotPortSelect, .pairControl, .transferIrqMask, .statusRead, .status, .irq_n);
`default_nettype wire

// ---- test/tdm_frame_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tdm_frame_peer (
    // Frame timing
    output logic      dcl,
    output logic      fsc,
    // Device drive
    input wire logic  duOut,
    input wire logic  duOe_n,
    input wire logic  ddOut,
    input wire logic  ddOe_n,
    // Resolved lines
    output logic      duLine,
    output logic      ddLine
);
    logic [7:0] cnt = 8'h00;
    logic [7:0] pat = 8'h00;
    logic       bitV = 1'b0;
    assign duLine = duOe_n ? bitV : duOut;
    assign ddLine = ddOe_n ? bitV : ddOut;
    // Slot n carries A0h+n, MSB first
    initial begin
        dcl = 1'b0;
        fsc = 1'b0;
        forever begin
            #100;
            dcl = 1'b1;
            fsc = (cnt == 8'h00);
            pat = {4'hA, cnt[7:4]};
            if (!cnt[0]) bitV = pat[~cnt[3:1]];
            #100;
            dcl = 1'b0;
            cnt = (cnt == 8'hBF) ? 8'h00 : cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ---- test/tdm_slot_access_unit_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module tdm_slot_access_unit_bench import tdm_slot_access_pkg::*; ;
    logic clk, reset, dcl, fsc, duOut, duOe_n, ddOut, ddOe_n, duLine, ddLine, statusRead, irq_n;
    slot_port_select_t [3:0] sel;
    pair_control_t [1:0]     pc;
    logic [7:0]              mask, wdata, status;
    logic [3:0]              ws, ack;
    logic [3:0][7:0]         rdata;
    int                      failures = 0, n_compared = 0;
    tdm_slot_access_unit tdm_slot_access_unit_inst (.clk, .reset, .dcl, .fsc, .duIn(duLine), .duOut, .duOe_n,
        .ddIn(ddLine), .ddOut, .ddOe_n, .slotPortSelect(sel), .pairControl(pc), .transferIrqMask(mask),
        .writeStrobe(ws), .writeData(wdata), .readData(rdata), .transferAck(ack), .statusRead, .status, .irq_n);
    tdm_frame_peer tdm_frame_peer_inst (.dcl, .fsc, .duOut, .duOe_n, .ddOut, .ddOe_n, .duLine, .ddLine);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic frames(input int n);
        repeat (n * 768) @(negedge clk);
    endtask
    task automatic end_sim;
        $display("compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic pulse_ack(input logic [3:0] which);
        ack = which;
        @(negedge clk) ack = 4'h0;
    endtask
    task automatic pulse_read;
        statusRead = 1'b1;
        @(negedge clk) statusRead = 1'b0;
        @(negedge clk);
    endtask
    task automatic t_loop;
        sel[0] = '{1'b0, 4'h2};
        sel[1] = '{1'b1, 4'h5};
        sel[2] = '{1'b0, 4'h8};
        pc[0] = '{1'b0, 1'b0, 2'b11, 2'b00};
        pc[1] = '{1'b1, 1'b0, 2'b01, 2'b00};
        frames(2);
        chk(rdata[0], 8'hA2);
        chk(rdata[1], 8'hA5);
        chk(rdata[2], 8'hAB);
        pc[0].swap = 1'b1;
        frames(2);
        chk(rdata[0], 8'hA5);
        chk(rdata[1], 8'hA2);
        $display("loop and swap done");
    endtask
    task automatic t_out;
        ws = 4'hA;
        wdata = 8'h5C;
        @(negedge clk) ws = 4'h0;
        sel[0] = '{1'b0, 4'h4};
        sel[1] = '{1'b1, 4'h4};
        sel[2] = '{1'b1, 4'h6};
        sel[3] = '{1'b0, 4'h6};
        pc[0] = '{1'b0, 1'b0, 2'b01, 2'b10};
        pc[1] = '{1'b0, 1'b0, 2'b01, 2'b10};
        frames(2);
        chk(rdata[0], 8'h5C);
        chk(rdata[1], 8'h5C);
        chk(rdata[2], 8'h5C);
        chk(rdata[3], 8'h5C);
        $display("output and hold done");
    endtask
    task automatic t_irq;
        sel[0] = '{1'b0, 4'h2};
        pc[0] = '{1'b0, 1'b0, 2'b01, 2'b00};
        pulse_read();
        mask = 8'hFE;
        frames(1);
        chk(status, 8'h01);
        chk({7'h00, irq_n}, 8'h00);
        pulse_read();
        chk(status, 8'h00);
        mask = 8'hEE;
        frames(2);
        chk(status & 8'h11, 8'h11);
        mask = 8'hFF;
        pulse_read();
        frames(1);
        chk(status, 8'h00);
        pulse_ack(4'hF);
        mask = 8'hEE;
        pulse_read();
        for (int i = 0; i < 800 && !status[0]; i++) @(negedge clk);
        chk(status, 8'h01);
        pulse_ack(4'h1);
        pulse_read();
        frames(1);
        chk(status, 8'h01);
        pulse_ack(4'h1);
        mask = 8'hED;
        pulse_read();
        frames(2);
        chk(status, 8'h12);
        $display("interrupts done");
    endtask
    initial begin
        #(30 * 768 * 50);
        failures++;
        end_sim();
    end
    initial begin
        reset = 1'b1;
        statusRead = 1'b0;
        ws = 4'h0;
        ack = 4'h0;
        wdata = 8'h00;
        mask = 8'hFF;
        sel = '0;
        pc = '0;
        repeat (10) @(negedge clk);
        chk(status, 8'h00);
        reset = 1'b0;
        @(negedge clk);
        t_loop();
        t_out();
        t_irq();
        end_sim();
    end
endmodule
`default_nettype wire
